/* File: core/hwt_regs.vh */
`ifndef HWT_REGS_VH
`define HWT_REGS_VH

// Register byte offsets
`define HWT_OFF_PRELOAD 4'h0
`define HWT_OFF_CONTROL 4'h4
`define HWT_OFF_COUNT 4'h8
`define HWT_ADDR_W 4

// Field layout and reset values
`define HWT_CTRL_RES_BIT 0
`define HWT_PRELOAD_RST 16'h0000
`define HWT_CONTROL_RST 16'h0000
`define HWT_COUNT_RST 16'h0000
`define HWT_ZERO16 16'h0000

// Timing: base period 30.5 us, coarse step 0.125 s = 4096 base ticks
`define HWT_FINE_PERIOD_NS 30500
`define HWT_COARSE_DIV 4096
`define HWT_CLKREQ_HOLD 2'h2
`define HWT_REQ_IDLE 2'h0
`define HWT_REQ_STEP 2'h1
`define HWT_DIV_W 12

`endif

/* File: core/hwt_prescaler.v */
`timescale 1ns/100ps
`include "hwt_regs.vh"

// Tick divider: one-cycle tick per clock (fine) or per DIV clocks (coarse)
module hwt_prescaler #(
    parameter DIV = `HWT_COARSE_DIV,
    parameter W = `HWT_DIV_W
) (
    ref_clk,
    nrst,
    run,
    coarse,
    tick
);
    input wire ref_clk;
    input wire nrst;
    input wire run;
    input wire coarse;
    output wire tick;

    reg [W-1:0] div_q;
    // Terminal value cut to the divider width on purpose
    localparam integer LAST_I = DIV - 1;
    localparam [W-1:0] LAST = LAST_I[W-1:0];
    wire [W-1:0] last = LAST;

    // Divider restarts whenever the counter is stopped or reloaded
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= {W{1'b0}};
        end else if (!run || !coarse || div_q == last) begin
            div_q <= {W{1'b0}};
        end else begin
            div_q <= div_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign tick = run & (!coarse | (div_q == last));
endmodule

/* File: core/hwt_wake_timer.v */
// Operation
// - The timer is a 16-bit counter that counts down once started.
// - It decrements once per 30.5 us or once per 0.125 s, by resolution.
// - Periods span about 30.5 us to 2 s fine, 0.125 s to 136.5 min coarse.
// - Writing a non-zero preload loads the counter and starts counting.
// - A wake interrupt is produced when the count reaches zero.
// - The event output fires only when enabled and decremented to zero.
// - The counter runs on the 32 kHz clock through a prescaler.
// - Counting goes on while the main oscillator is stopped.
// - Sleep enable inputs are ignored.
// - Clock request is raised only around register accesses.
// - System reset returns all logic and registers to defaults.
// - Preload sits at 00h, control at 04h, count at 08h.
// - Writing zero to preload disables the counter.
// - Control bit 0 set selects 0.125 s per count, clear 30.5 us.
// - Reading count returns the counter value without changing it.
`timescale 1ns/100ps
`include "hwt_regs.vh"

module hwt_wake_timer #(
    parameter COUNT_W = 16,
    parameter COARSE_DIV = `HWT_COARSE_DIV
) (
    ref_clk,
    nrst,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    sleep_en,
    clk_req,
    wake_timer_event
);
    input wire ref_clk; // 32 kHz always-on clock, here modelled at 10 MHz
    input wire nrst; // system_reset, active low
    input wire [`HWT_ADDR_W-1:0] reg_addr;
    input wire reg_wr;
    input wire reg_rd;
    input wire [15:0] reg_wdata;
    output reg [15:0] reg_rdata;
    input wire sleep_en;
    output reg clk_req;
    output reg wake_timer_event;

    // Counter states: idle holds the count, run lets ticks through
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    // Fixed values at the widths they meet
    localparam [COUNT_W-1:0] CNT_ZERO = {COUNT_W{1'b0}};
    localparam [COUNT_W-1:0] CNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};
    localparam [COUNT_W-1:0] PRELOAD_RST = `HWT_PRELOAD_RST;
    localparam [COUNT_W-1:0] COUNT_RST = `HWT_COUNT_RST;
    localparam [14:0] CTRL_PAD = 15'h0000;
    localparam [15:0] RDATA_RST = `HWT_ZERO16;
    localparam [1:0] REQ_RST = `HWT_REQ_IDLE;

    // Timer state and its next value
    reg state_q;
    reg state_d;
    reg [COUNT_W-1:0] count_q;
    reg [COUNT_W-1:0] count_d;

    // Event next value
    reg event_d;

    // Software-visible registers and their next values
    reg [COUNT_W-1:0] preload_q;
    reg [COUNT_W-1:0] preload_d;
    reg coarse_q;
    reg coarse_d;
    reg [15:0] rdata_d;

    // Clock request hold counter and its next value
    reg [1:0] req_cnt_q;
    reg [1:0] req_cnt_d;
    reg clk_req_d;

    // Address decode results, one hot
    reg hit_pre;
    reg hit_ctl;
    reg hit_cnt;
    reg hit_none;

    // Prescaler tick, one cycle wide
    wire tick;

    // Write strobes
    wire wr_pre = reg_wr && hit_pre;
    wire wr_ctl = reg_wr && hit_ctl;

    // Read strobes
    wire rd_pre = reg_rd && hit_pre;
    wire rd_ctl = reg_rd && hit_ctl;
    wire rd_cnt = reg_rd && hit_cnt;
    wire rd_none = reg_rd && hit_none;
    wire any_acc = reg_wr || reg_rd;

    // Counter compares
    wire wr_zero = (reg_wdata[COUNT_W-1:0] == CNT_ZERO);
    wire at_one = (count_q == CNT_ONE);
    wire running = (state_q == ST_RUN);
    wire pre_run = running && !wr_pre;
    wire expire = running && tick && at_one;
    wire req_busy = (req_cnt_q != `HWT_REQ_IDLE);

    // Sleep enable has no path into the logic; ref_clk alone drives it
    wire unused_sleep = sleep_en;

    // Address decode; unmapped offsets read zero and drop writes
    always @* begin
        hit_pre = 1'b0;
        hit_ctl = 1'b0;
        hit_cnt = 1'b0;
        hit_none = 1'b0;
        if (reg_addr == `HWT_OFF_PRELOAD) begin
            hit_pre = 1'b1;
        end else if (reg_addr == `HWT_OFF_CONTROL) begin
            hit_ctl = 1'b1;
        end else if (reg_addr == `HWT_OFF_COUNT) begin
            hit_cnt = 1'b1;
        end else begin
            hit_none = 1'b1;
        end
    end

    // Divider restarts on reload, so the first step is a whole one
    hwt_prescaler #(
        .DIV(COARSE_DIV),
        .W(`HWT_DIV_W)
    ) u_pre (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(pre_run),
        .coarse(coarse_q),
        .tick(tick)
    );

    // Next preload value; reads back the last write
    always @* begin
        preload_d = preload_q;
        if (wr_pre) begin
            preload_d = reg_wdata[COUNT_W-1:0];
        end
    end

    // Next resolution; takes effect at once, prescaler held at zero while fine
    always @* begin
        coarse_d = coarse_q;
        if (wr_ctl) begin
            coarse_d = reg_wdata[`HWT_CTRL_RES_BIT];
        end
    end

    // Next state; zero preload or expiry parks the counter
    always @* begin
        state_d = state_q;
        if (wr_pre) begin
            if (wr_zero) begin
                state_d = ST_IDLE;
            end else begin
                state_d = ST_RUN;
            end
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (expire) begin
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // Next count; a preload write wins over a tick in the same cycle
    always @* begin
        count_d = count_q;
        if (wr_pre) begin
            count_d = reg_wdata[COUNT_W-1:0];
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (tick) begin
                        count_d = count_q - CNT_ONE;
                    end
                end
                default: begin
                    count_d = count_q;
                end
            endcase
        end
    end

    // Event only on a real 1 to 0 step, never on a load
    always @* begin
        event_d = 1'b0;
        if (!wr_pre && expire) begin
            event_d = 1'b1;
        end
    end

    // Read mux; reading never disturbs the count
    always @* begin
        rdata_d = reg_rdata;
        if (rd_pre) begin
            rdata_d = preload_q;
        end else if (rd_ctl) begin
            rdata_d = {CTRL_PAD, coarse_q};
        end else if (rd_cnt) begin
            rdata_d = count_q;
        end else if (rd_none) begin
            rdata_d = `HWT_ZERO16;
        end
    end

    // Hold the request past the access so writes reach the core
    always @* begin
        req_cnt_d = req_cnt_q;
        if (any_acc) begin
            req_cnt_d = `HWT_CLKREQ_HOLD;
        end else if (req_busy) begin
            req_cnt_d = req_cnt_q - `HWT_REQ_STEP;
        end
        clk_req_d = any_acc || req_busy;
    end

    // Run state flop
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Count flop
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // Event flop, one-cycle pulse to the interrupt aggregator
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wake_timer_event <= 1'b0;
        end else begin
            wake_timer_event <= event_d;
        end
    end

    // Preload register
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            preload_q <= PRELOAD_RST;
        end else begin
            preload_q <= preload_d;
        end
    end

    // Resolution bit
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            coarse_q <= 1'b0;
        end else begin
            coarse_q <= coarse_d;
        end
    end

    // Read data, held until the next read
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= RDATA_RST;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // Request hold counter
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req_cnt_q <= REQ_RST;
        end else begin
            req_cnt_q <= req_cnt_d;
        end
    end

    // Clock request output
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_req <= 1'b0;
        end else begin
            clk_req <= clk_req_d;
        end
    end
endmodule

/* File: tb/hwt_chk_assertions.sv */
`timescale 1ns/100ps
// Port checks of the wake timer
module hwt_chk (
    input wire ref_clk,
    input wire nrst,
    input wire [3:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire clk_req,
    input wire wake_timer_event
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_ctrl_read: assert property (reg_rd && reg_addr == 4'h4
        |=> reg_rdata[15:1] == 15'h0) else $error("ctrl high bits");
    chk_unmapped_read: assert property (reg_rd && reg_addr == 4'hc
        |=> reg_rdata == 16'h0) else $error("unmapped data");
    chk_preload_back: assert property (reg_wr && reg_addr == 4'h0 ##1 !reg_wr
        ##1 reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(reg_wdata, 3)) else $error("preload");
    chk_req_hold: assert property (reg_wr || reg_rd |=> clk_req [*3])
        else $error("req short");
    chk_req_idle: assert property ((!reg_wr && !reg_rd) [*3] |=> !clk_req)
        else $error("req idle");
    chk_event_single: assert property (wake_timer_event |=> !wake_timer_event)
        else $error("long event");
    chk_stop_quiet: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata == 16'h0
        |-> ##2 !wake_timer_event [*2]) else $error("event after stop");
    chk_reset_quiet: assert property (disable iff (1'b0) !nrst
        |-> !clk_req && !wake_timer_event && reg_rdata == 16'h0) else $error("reset");
endmodule

bind hwt_wake_timer hwt_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .clk_req(clk_req), .wake_timer_event(wake_timer_event));

/* File: tb/hwt_wake_timer_tb.sv */
`timescale 1ns/100ps
module hwt_wake_timer_tb;
    reg ref_clk = 1'b0, nrst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sleep_en = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0, n;
    reg [31:0] seed = 32'h72a8;
    wire [15:0] reg_rdata;
    wire clk_req, wake_timer_event;
    integer miscompares = 0, checked = 0, cyc = 0, c, t;
    // Clock of 100 ns period
    always #50 ref_clk = ~ref_clk;
    hwt_wake_timer #(.COARSE_DIV(4)) DUT (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sleep_en(sleep_en), .clk_req(clk_req), .wake_timer_event(wake_timer_event));
    // Pseudo-random source
    function [31:0] lf(input [31:0] s);
        lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task ck(input [15:0] g, e);
        checked = checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0t %h %h", $time, g, e);
        end
    endtask
    // One access; a read compares against d
    task acc(input w, input [3:0] a, input [15:0] d);
        @(posedge ref_clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge ref_clk) #1;
        {reg_wr, reg_rd} = 2'h0;
        if (!w) ck(reg_rdata, d);
    endtask
    task conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1 nrst = 1'b1;
        acc(0, 4'h0, 16'h0);
        acc(0, 4'h8, 16'h0);
        acc(0, 4'hc, 16'h0);
        $display("reset values done");
        // Random preloads, both resolutions; sleep input must not matter
        for (t = 0; t < 6; t = t + 1) begin
            seed = lf(seed);
            n = (t == 0) ? 16'h1 : {12'h0, seed[3:0]} + 16'h1;
            sleep_en = seed[9];
            acc(1, 4'h4, {15'h7fff, t[0]});
            acc(0, 4'h4, {15'h0, t[0]});
            acc(1, 4'h0, n);
            for (c = 0; wake_timer_event !== 1'b1 && c < 200; c = c + 1) @(posedge ref_clk) #1;
            ck({15'h0, c >= n * (t[0] ? 4 : 1) && c <= n * (t[0] ? 4 : 1) + 1}, 16'h1);
            acc(0, 4'h8, 16'h0);
            $display("countdown %0d done", t);
        end
        // Zero preload halts a running count
        acc(1, 4'h0, 16'h40);
        acc(0, 4'h8, 16'h40);
        acc(1, 4'h0, 16'h0);
        acc(0, 4'h8, 16'h0);
        for (c = 0; wake_timer_event !== 1'b1 && c < 300; c = c + 1) @(posedge ref_clk) #1;
        ck(c[15:0], 16'h12c);
        $display("stop done");
        // Reset in mid-count
        acc(1, 4'h0, 16'h9);
        acc(0, 4'h0, 16'h9);
        @(posedge ref_clk) #1;
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk) #1;
        nrst = 1'b1;
        acc(0, 4'h0, 16'h0);
        acc(0, 4'h4, 16'h0);
        acc(0, 4'h8, 16'h0);
        $display("late reset done");
        conclude;
    end
endmodule
